// *** alufx_core.v ***
`timescale 1ns/100ps
`include "alufx_consts.vh"
// Overview of operation
// - add literal opcode: W plus literal into W, update C, digit carry, Z
// - and literal opcode: W and literal into W, only Z updated
// - add file opcode: W plus file into destination, update C, digit carry, Z
// - and file opcode: W and file into destination, only Z updated
// - destination bit clear: result to W, file untouched
// - destination bit set: file ops write result to file, W untouched; literal ops still write W
// - literal ops: one word, one cycle: decode, read literal, compute, write W
// - file ops: one cycle: decode, read file, compute, write destination
// - each instruction cycle is four consecutive clock periods
module alufx_core (
    input wire REF_CLK,
    input wire RST_B,
    input wire [13:0] INSTR,
    input wire [7:0] FILE_RDATA,
    output reg [1:0] PHASE,
    output reg [6:0] FILE_ADDR,
    output reg FILE_RD,
    output reg FILE_WR,
    output reg [7:0] FILE_WDATA,
    output reg [7:0] W_OUT,
    output reg CARRY,
    output reg DIGIT_CARRY_FLAG,
    output reg ZERO,
    output reg OP_DONE
);
    // ==========================================================
    // phase counter and pipeline registers
    reg [1:0] phase_r;
    reg [13:0] ir_r;
    reg [7:0] opnd_r;
    reg [7:0] res_r;
    reg cy_r;
    reg nib_cy_r;
    reg z_r;

    // decoded operation class of the latched word
    reg add_literal_op;
    reg and_literal_op;
    reg add_file_op;
    reg and_file_op;
    reg dest_file;

    // next values, settled before the clock edge that loads them
    reg rd_nxt;
    reg [7:0] w_nxt;
    reg carry_nxt;
    reg nib_cy_nxt;
    reg zero_nxt;
    reg wr_nxt;
    reg [7:0] wdata_nxt;
    reg done_nxt;

    // opcode fields and arithmetic results
    wire [5:0] opc;
    wire [5:0] opc_in;
    wire [7:0] alu_res;
    wire alu_cy;
    wire alu_nib_cy;
    wire alu_z;

    // operation groups; a refused opcode raises none of them
    wire is_lit_op;
    wire is_file_op;
    wire is_add;
    wire is_and;
    wire any_op;
    wire to_w;
    wire to_file;

    // the latched word drives execution, the incoming word the read strobe and the file address
    assign opc = ir_r[`ALUFX_OP_HI:`ALUFX_OP_LO];
    assign opc_in = INSTR[`ALUFX_OP_HI:`ALUFX_OP_LO];

    // group the four decoded operations
    assign is_lit_op = add_literal_op | and_literal_op;
    assign is_file_op = add_file_op | and_file_op;
    assign is_add = add_literal_op | add_file_op;
    assign is_and = and_literal_op | and_file_op;
    assign any_op = is_lit_op | is_file_op;

    // destination: literal ops always land in W, file ops follow the direction bit
    assign to_w = is_lit_op | (is_file_op & ~dest_file);
    assign to_file = is_file_op & dest_file;

    // four clock periods form one instruction cycle
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            phase_r <= `ALUFX_PH_DECODE;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // ==========================================================
    // decode: classify the latched word
    always @* begin
        add_literal_op = ((opc & `ALUFX_OPC_ADD_LIT_MASK) == `ALUFX_OPC_ADD_LIT_VAL);
        and_literal_op = (opc == `ALUFX_OPC_AND_LIT);
        add_file_op = (opc == `ALUFX_OPC_ADD_FILE);
        and_file_op = (opc == `ALUFX_OPC_AND_FILE);
        dest_file = ir_r[`ALUFX_DEST_BIT];
    end

    // read strobe comes from the incoming word so the file answers within the read phase
    always @* begin
        rd_nxt = 1'b0;
        if (phase_r == `ALUFX_PH_DECODE) begin
            if ((opc_in == `ALUFX_OPC_ADD_FILE) || (opc_in == `ALUFX_OPC_AND_FILE)) begin
                rd_nxt = 1'b1;
            end
        end
    end

    alufx_flags u_alu (
        .a(W_OUT),
        .b(opnd_r),
        .do_and(is_and),
        .res(alu_res),
        .cy(alu_cy),
        .nib_cy(alu_nib_cy),
        .z(alu_z)
    );

    // ==========================================================
    // write phase: next values of W, flags and the file write port
    // a refused word leaves every value as it was
    always @* begin
        w_nxt = W_OUT;
        carry_nxt = CARRY;
        nib_cy_nxt = DIGIT_CARRY_FLAG;
        zero_nxt = ZERO;
        wr_nxt = 1'b0;
        wdata_nxt = FILE_WDATA;
        done_nxt = 1'b0;
        if (phase_r == `ALUFX_PH_WRITE) begin
            done_nxt = any_op;
            if (to_w) begin
                w_nxt = res_r;
            end
            if (to_file) begin
                wr_nxt = 1'b1;
                wdata_nxt = res_r;
            end
            if (any_op) begin
                zero_nxt = z_r;
            end
            // logic ops leave carry and digit carry alone
            if (is_add) begin
                carry_nxt = cy_r;
                nib_cy_nxt = nib_cy_r;
            end
        end
    end

    // ==========================================================
    // operand pipeline across decode, read and execute
    // the word is sampled once in decode so a changing bus mid-cycle is harmless
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ir_r <= 14'h0000;
            opnd_r <= 8'h00;
            res_r <= 8'h00;
            cy_r <= 1'b0;
            nib_cy_r <= 1'b0;
            z_r <= 1'b0;
        end else begin
            case (phase_r)
                `ALUFX_PH_DECODE: begin
                    ir_r <= INSTR;
                end
                `ALUFX_PH_READ: begin
                    // file data is valid one clock after the read strobe
                    opnd_r <= is_file_op ? FILE_RDATA : ir_r[7:0];
                end
                `ALUFX_PH_EXEC: begin
                    res_r <= alu_res;
                    cy_r <= alu_cy;
                    nib_cy_r <= alu_nib_cy;
                    z_r <= alu_z;
                end
                default: begin
                    // write phase: the pipeline holds while results are stored
                    ir_r <= ir_r;
                end
            endcase
        end
    end

    // ==========================================================
    // file port: address and read strobe from decode, write pulse from the write phase
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PHASE <= `ALUFX_PH_DECODE;
            FILE_ADDR <= 7'h00;
            FILE_RD <= 1'b0;
            FILE_WR <= 1'b0;
            FILE_WDATA <= 8'h00;
        end else begin
            PHASE <= phase_r;
            FILE_RD <= rd_nxt;
            FILE_WR <= wr_nxt;
            FILE_WDATA <= wdata_nxt;
            // address held for the whole cycle so the file can use it at write time
            if (phase_r == `ALUFX_PH_DECODE) begin
                FILE_ADDR <= INSTR[`ALUFX_FADDR_HI:0];
            end
        end
    end

    // ==========================================================
    // architectural state: W and status flags, with the done pulse
    // flags reset to zero, so they are defined before the first instruction
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            W_OUT <= `ALUFX_W_RST;
            CARRY <= 1'b0;
            DIGIT_CARRY_FLAG <= 1'b0;
            ZERO <= 1'b0;
            OP_DONE <= 1'b0;
        end else begin
            W_OUT <= w_nxt;
            CARRY <= carry_nxt;
            DIGIT_CARRY_FLAG <= nib_cy_nxt;
            ZERO <= zero_nxt;
            OP_DONE <= done_nxt;
        end
    end
endmodule

// *** alufx_consts.vh ***
`ifndef ALUFX_CONSTS_VH
`define ALUFX_CONSTS_VH
// ==========================================================
// instruction word layout
`define ALUFX_OP_HI 13
`define ALUFX_OP_LO 8
`define ALUFX_DEST_BIT 7
`define ALUFX_FADDR_HI 6
// opcode patterns, upper six bits
`define ALUFX_OPC_ADD_LIT_MASK 6'h3E
`define ALUFX_OPC_ADD_LIT_VAL 6'h3E
`define ALUFX_OPC_AND_LIT 6'h39
`define ALUFX_OPC_ADD_FILE 6'h07
`define ALUFX_OPC_AND_FILE 6'h05
// phase codes
`define ALUFX_PH_DECODE 2'h0
`define ALUFX_PH_READ 2'h1
`define ALUFX_PH_EXEC 2'h2
`define ALUFX_PH_WRITE 2'h3
// reset values
`define ALUFX_W_RST 8'h00
`endif

// *** alufx_flags.v ***
`timescale 1ns/100ps
// ==========================================================
// arithmetic unit: add or and, with carry, digit carry, zero
module alufx_flags (
    input wire [7:0] a,
    input wire [7:0] b,
    input wire do_and,
    output wire [7:0] res,
    output wire cy,
    output wire nib_cy,
    output wire z
);
    wire [8:0] sum;
    wire [4:0] lo_sum;
    // nine-bit sum keeps the carry out of bit 7
    assign sum = {1'b0, a} + {1'b0, b};
    assign lo_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    assign res = do_and ? (a & b) : sum[7:0];
    assign cy = sum[8];
    assign nib_cy = lo_sum[4];
    assign z = (res == 8'h00);
endmodule

// *** alufx_props.sv ***
`timescale 1ns/100ps
// ==========
// phase and flag checks
module alufx_props (
    input wire REF_CLK,
    input wire RST_B,
    input wire [1:0] PHASE,
    input wire FILE_RD,
    input wire FILE_WR,
    input wire [7:0] FILE_WDATA,
    input wire [7:0] W_OUT,
    input wire ZERO,
    input wire OP_DONE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    a_phase_cycle: assert property (OP_DONE |=> PHASE == 2'h0 ##1 PHASE == 2'h1 ##1 PHASE == 2'h2)
        else $error("phase order broken");
    a_done_phase: assert property (OP_DONE |-> PHASE == 2'h3)
        else $error("done off phase");
    a_rd_decode: assert property (FILE_RD |-> PHASE == 2'h0)
        else $error("read off phase");
    a_wr_after_rd: assert property (FILE_WR |-> OP_DONE && $past(FILE_RD, 3))
        else $error("write without read");
    a_wr_keeps_w: assert property (FILE_WR |-> $stable(W_OUT))
        else $error("w changed on file write");
    a_w_write_only: assert property (!OP_DONE |-> $stable(W_OUT))
        else $error("w changed off write");
    a_zero_result: assert property (OP_DONE |-> ZERO == ((FILE_WR ? FILE_WDATA : W_OUT) == 8'h00))
        else $error("zero flag wrong");
    a_zero_hold: assert property (!OP_DONE |-> $stable(ZERO))
        else $error("zero changed off write");
endmodule
bind alufx_core alufx_props u_props (.REF_CLK(REF_CLK), .RST_B(RST_B), .PHASE(PHASE), .FILE_RD(FILE_RD),
    .FILE_WR(FILE_WR), .FILE_WDATA(FILE_WDATA), .W_OUT(W_OUT), .ZERO(ZERO), .OP_DONE(OP_DONE));

// *** alufx_tb.sv ***
`timescale 1ns/100ps
// ==========
// bench: one instruction every four clocks
module tb_top;
    localparam [35:0] OPS = {6'h3E, 6'h3F, 6'h39, 6'h07, 6'h05, 6'h06};
    reg REF_CLK = 1'b0;
    reg RST_B = 1'b0;
    reg [13:0] INSTR = 14'h0000;
    reg [7:0] FILE_RDATA = 8'h00;
    wire [1:0] PHASE;
    wire [6:0] FILE_ADDR;
    wire [7:0] FILE_WDATA, W_OUT;
    wire FILE_RD, FILE_WR, CARRY, DIGIT_CARRY_FLAG, ZERO, OP_DONE;
    reg [7:0] w = 8'h00;
    reg c = 1'b0, hc = 1'b0, z = 1'b0;
    integer errors = 0, n_tests = 0, cyc = 0, n, k;
    reg [13:0] i;
    alufx_core dut (.REF_CLK(REF_CLK), .RST_B(RST_B), .INSTR(INSTR), .FILE_RDATA(FILE_RDATA), .PHASE(PHASE),
        .FILE_ADDR(FILE_ADDR), .FILE_RD(FILE_RD), .FILE_WR(FILE_WR), .FILE_WDATA(FILE_WDATA), .W_OUT(W_OUT),
        .CARRY(CARRY), .DIGIT_CARRY_FLAG(DIGIT_CARRY_FLAG), .ZERO(ZERO), .OP_DONE(OP_DONE));
    always #5 REF_CLK = ~REF_CLK;
    // run is ~830 clocks, so 2000 means a hang
    always @(posedge REF_CLK) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            errors = errors + 1;
            summarize;
        end
    end
    task check(input [47:0] nm, input [7:0] e, input [7:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("mismatch %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // drive one word half a clock before the decode edge, check after the write edge
    task run(input [13:0] ins, input [7:0] f);
        reg [8:0] s;
        reg [7:0] b, r;
        reg ad, ok, fw;
        begin
            b = ins[13] ? ins[7:0] : f;
            ad = ins[13:9] == 5'h1F || ins[13:8] == 6'h07;
            ok = ad || ins[13:8] == 6'h39 || ins[13:8] == 6'h05;
            fw = ok && !ins[13] && ins[7];
            s = w + b;
            r = ad ? s[7:0] : (w & b);
            INSTR = ins;
            FILE_RDATA = f;
            @(posedge REF_CLK);
            @(negedge REF_CLK);
            check("rd", ins[13:8] == 6'h07 || ins[13:8] == 6'h05, FILE_RD);
            check("phase", 8'h00, PHASE);
            repeat (3) @(posedge REF_CLK);
            @(negedge REF_CLK);
            if (ok) begin
                if (ad) c = s[8];
                if (ad) hc = ((w & 8'h0F) + (b & 8'h0F)) > 8'h0F;
                z = r == 8'h00;
                if (fw) check("wdata", r, FILE_WDATA);
                else w = r;
            end
            if (!ins[13]) check("addr", ins[6:0], FILE_ADDR);
            check("w", w, W_OUT);
            check("flags", {c, hc, z}, {CARRY, DIGIT_CARRY_FLAG, ZERO});
            check("wr", fw, FILE_WR);
            check("done", ok, OP_DONE);
            check("phase", 8'h03, PHASE);
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", n_tests, errors);
            if (errors == 0 && n_tests > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    // corners first: wrap to zero, file write-back, refused opcode
    initial begin
        void'($urandom(32'h01BF));
        repeat (3) @(negedge REF_CLK);
        RST_B = 1'b1;
        run(14'h3EFF, 8'h00);
        run(14'h3F01, 8'h00);
        run(14'h39A3, 8'h00);
        run(14'h07AA, 8'hC2);
        run(14'h052A, 8'h5F);
        run(14'h0612, 8'h33);
        $display("test corner done");
        for (n = 0; n < 200; n = n + 1) begin
            k = $urandom % 6;
            i = 14'($urandom);
            i[13:8] = OPS[6 * k +: 6];
            run(i, 8'($urandom));
        end
        $display("test random done");
        summarize;
    end
endmodule
